/* File: hw/ovc_ctl.sv */
`timescale 1ns/1ns
// How it works
// - config overlay: no sector, word 0 only
// - config overlay reads and programs word 0
// - password overlay maps words 0 to 3
// - matching password unlock sets global lock
// - persistent bit per sector at bit 0
// - persistent overlay erase clears all sectors while global lock is set
// - lock overlay shows lock, program only clears
// - volatile bit per sector, set or clear
// - legacy or common exit leaves protection overlays
// - correction overlay returns half-page status bits 4:0
// - correction overlay reads traps, counter; exit
// - crc overlay covers array unless suspended
// - crc overlay enables its own command set
// - reset leaves id mode, clears timeout flag
// - reset ignored while operation runs
// - reset keeps settings, returns to read mode
// - reset completes within the write pulse
// - error clear keeps overlay, else suspend/standby
// - failed operation holds ready with error bits
// - error bits: erase 5, program 4, 2:1 zero
// - reset or status clear ends the error
// - during error only read, reset, clear accepted
// - status read captures status for next read
module ovc_ctl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_ck,
  input wire ovc_pkg::ovc_req_s link_req,
  input wire logic [15:0] array_data,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic op_timeout,
  input wire logic erase_susp,
  input wire logic [4:0] ecc_status,
  input wire logic [15:0] ecc_trap_lo,
  input wire logic [15:0] ecc_trap_hi,
  input wire logic [15:0] ecc_count,
  input wire logic [31:0] crc_value,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [7:0] status_word,
  output ovc_pkg::ovc_ov_e overlay,
  output ovc_pkg::ovc_ctl_e ctl_state,
  output logic op_start,
  output ovc_pkg::ovc_op_e op_kind,
  output logic [7:0] op_addr,
  output logic [15:0] op_data,
  output logic [7:0] crc_start_addr,
  output logic [7:0] crc_end_addr,
  output logic crc_run,
  output logic crc_suspended,
  output logic global_protect_lock,
  output logic [7:0] persistent_protect_bit,
  output logic [7:0] volatile_protect_bit,
  output logic polling_timeout_flag
);
  import ovc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // link sampling: two flops on clock and request, then edge find
  logic ck_s1, ck_s2, ck_d;
  ovc_req_s req_s1, req_s2;

  // the link signals come from another domain, so nothing reads stage one
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d <= 1'b0;
      req_s1 <= '0;
      req_s2 <= '0;
    end else begin
      ck_s1 <= link_ck;
      ck_s2 <= ck_s1;
      ck_d <= ck_s2;
      req_s1 <= link_req;
      req_s2 <= req_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode
  wire edge_hit = ck_s2 & ~ck_d;
  wire do_wr = edge_hit & req_s2.wr;
  wire do_rd = edge_hit & req_s2.rd & ~req_s2.wr;
  wire ovc_cmd_e cmd = req_s2.cmd;
  wire [7:0] addr = req_s2.addr;
  wire [15:0] data = req_s2.data;
  wire [2:0] sect = addr[7:SECT_LSB];
  wire busy = (ctl_state == CS_BUSY);
  wire err = (ctl_state == CS_ERROR);
  wire crc_held = (overlay == OV_CRC) & crc_suspended;
  // filter: busy takes only status read, error takes three, suspended crc few
  wire err_ok = (cmd inside {CMD_SR_READ, CMD_RESET, CMD_SR_CLEAR});
  wire crc_ok = (cmd inside {CMD_CRC_RESUME, CMD_EXIT, CMD_SR_READ});
  wire take = do_wr & (busy ? (cmd == CMD_SR_READ) :
                       err ? err_ok :
                       crc_held ? crc_ok : 1'b1);
  wire read_mode = (overlay == OV_NORMAL) & (ctl_state != CS_ERROR);
  wire c_reset = take & (cmd == CMD_RESET);
  wire c_clear = take & (cmd == CMD_SR_CLEAR) & err;
  wire c_pgm = take & (cmd == CMD_WORD_PGM);
  wire c_erase = take & (cmd == CMD_ERASE);
  wire in_crc = take & (overlay == OV_CRC);
  // protection overlays also take the legacy exit
  wire prot_ov = (overlay inside {OV_CFG, OV_PWD, OV_PPB, OV_LOCK, OV_DYB});
  wire c_exit = take & ((cmd == CMD_EXIT) |
                        ((cmd == CMD_LEGACY_EXIT) & prot_ov));
  // array operations only start from the normal map
  wire op_go = take & read_mode & (cmd inside {CMD_WORD_PGM, CMD_ERASE,
                                               CMD_BLANK_CHECK});

  ////////////////////////////////////////////////////////////////////
  // password unlock: words gather by address, word 3 triggers compare
  logic [15:0] pw [PWD_WORDS];
  logic [15:0] pw_try [PWD_WORDS];
  wire c_unlock = take & (overlay == OV_PWD) & (cmd == CMD_PWD_UNLOCK);
  wire unlock_last = c_unlock & (addr[1:0] == 2'h3);
  wire pw_match = (pw[0] == pw_try[0]) & (pw[1] == pw_try[1]) &
                  (pw[2] == pw_try[2]) & (pw[3] == data);
  wire unlock_ok = unlock_last & pw_match;
  wire unlock_bad = unlock_last & ~pw_match;

  ////////////////////////////////////////////////////////////////////
  // controller state
  ovc_ctl_e next_ctl;
  wire ovc_ctl_e rest_state = erase_susp ? CS_ESUSP : CS_STANDBY;
  always_comb begin
    next_ctl = ctl_state;
    unique case (ctl_state)
      CS_BUSY: begin
        if (op_fail) begin
          next_ctl = CS_ERROR;
        end else if (op_done) begin
          next_ctl = rest_state;
        end
      end
      CS_ERROR: begin
        if (c_reset) begin
          next_ctl = CS_STANDBY;
        end else if (c_clear) begin
          next_ctl = rest_state;
        end
      end
      CS_STANDBY, CS_ESUSP: begin
        if (c_reset) begin
          next_ctl = CS_STANDBY;
        end else if (op_go) begin
          next_ctl = CS_BUSY;
        end else if (unlock_bad) begin
          next_ctl = CS_ERROR;
        end else begin
          next_ctl = rest_state;
        end
      end
    endcase
  end

  // error cause bits latched on the way into error, dropped on leaving
  logic err_erase, err_pgm;
  ovc_op_e run_kind;
  wire to_err = (next_ctl == CS_ERROR) & ~err;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_state <= CS_STANDBY;
      err_erase <= 1'b0;
      err_pgm <= 1'b0;
    end else begin
      ctl_state <= next_ctl;
      if (to_err) begin
        err_erase <= busy & (run_kind != OP_PGM);
        err_pgm <= ~busy | (run_kind == OP_PGM);
      end else if (next_ctl != CS_ERROR) begin
        err_erase <= 1'b0;
        err_pgm <= 1'b0;
      end
    end
  end

  // operation launch towards the engine
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_start <= 1'b0;
      op_kind <= OP_PGM;
      run_kind <= OP_PGM;
      op_addr <= '0;
      op_data <= '0;
    end else begin
      op_start <= op_go;
      if (op_go) begin
        op_kind <= (cmd == CMD_WORD_PGM) ? OP_PGM :
                   (cmd == CMD_ERASE) ? OP_ERASE : OP_BLANK;
        run_kind <= (cmd == CMD_WORD_PGM) ? OP_PGM :
                    (cmd == CMD_ERASE) ? OP_ERASE : OP_BLANK;
        op_addr <= addr;
        op_data <= data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status word; bits 3 to 0 read as zero
  wire [7:0] next_status = {~busy, erase_susp, err & err_erase,
                            err & err_pgm, 4'h0};
  // timeout flag: the engine event wins over a reset in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_word <= 8'h80;
      polling_timeout_flag <= 1'b0;
    end else begin
      status_word <= next_status;
      polling_timeout_flag <= op_timeout | (polling_timeout_flag & ~c_reset);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // overlay selection; a status clear leaves the overlay as it was
  ovc_ov_e next_ov;
  always_comb begin
    next_ov = overlay;
    if (c_reset | c_exit) begin
      next_ov = OV_NORMAL;
    end else if (take & read_mode) begin
      unique case (cmd)
        CMD_ENTER_CFG: next_ov = OV_CFG;
        CMD_ENTER_PWD: next_ov = OV_PWD;
        CMD_ENTER_PPB: next_ov = OV_PPB;
        CMD_ENTER_LOCK: next_ov = OV_LOCK;
        CMD_ENTER_DYB: next_ov = OV_DYB;
        CMD_ENTER_ECC: next_ov = OV_ECC;
        CMD_ENTER_CRC: next_ov = OV_CRC;
        CMD_ENTER_ID: next_ov = OV_IDQ;
        default: next_ov = overlay;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overlay <= OV_NORMAL;
    end else begin
      overlay <= next_ov;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // protection bits and config word; a reset command touches none
  logic [15:0] cfg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg <= CFG_RST;
      global_protect_lock <= LOCK_RST;
      persistent_protect_bit <= '0;
      volatile_protect_bit <= '0;
      for (int i = 0; i < PWD_WORDS; i++) begin
        pw[i] <= PWD_RST;
        pw_try[i] <= PWD_RST;
      end
    end else begin
      if (c_pgm & (overlay == OV_CFG) & (addr == CFG_ADDR))
        cfg <= data;
      if (c_pgm & (overlay == OV_PWD) & (addr < 8'h04))
        pw[addr[1:0]] <= data;
      if (c_unlock)
        pw_try[addr[1:0]] <= data;
      if (unlock_ok)
        global_protect_lock <= 1'b1;
      else if (c_pgm & (overlay == OV_LOCK) & ~data[0])
        global_protect_lock <= 1'b0;
      if (c_erase & (overlay == OV_PPB) & global_protect_lock)
        persistent_protect_bit <= '0;
      else if (c_pgm & (overlay == OV_PPB) & global_protect_lock)
        persistent_protect_bit[sect] <= 1'b1;
      if (c_pgm & (overlay == OV_DYB))
        volatile_protect_bit[sect] <= data[0];
    end
  end

  // crc bounds and run control; leaving the overlay clears run and suspend, bounds kept
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      crc_start_addr <= '0;
      crc_end_addr <= '0;
      crc_run <= 1'b0;
      crc_suspended <= 1'b0;
    end else begin
      if (in_crc & (cmd == CMD_CRC_START))
        crc_start_addr <= addr;
      if (in_crc & (cmd == CMD_CRC_END))
        crc_end_addr <= addr;
      if (next_ov != OV_CRC) begin
        crc_run <= 1'b0;
        crc_suspended <= 1'b0;
      end else if (in_crc & (cmd == CMD_CRC_END)) begin
        crc_run <= 1'b1;
      end else if (in_crc & (cmd == CMD_CRC_SUSPEND) & crc_run) begin
        crc_suspended <= 1'b1;
      end else if (in_crc & (cmd == CMD_CRC_RESUME)) begin
        crc_suspended <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status read capture: next read returns it, map left untouched
  logic sr_pend;
  logic [7:0] sr_snap;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sr_pend <= 1'b0;
      sr_snap <= '0;
    end else if (take & (cmd == CMD_SR_READ)) begin
      sr_pend <= 1'b1;
      sr_snap <= next_status;
    end else if (do_rd) begin
      sr_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data selection; undefined spots give a fixed filler word
  wire [15:0] w_cfg = (addr == CFG_ADDR) ? cfg : UNDEF_WORD;
  wire [15:0] w_pwd = (addr < 8'h04) ? pw[addr[1:0]] : UNDEF_WORD;
  wire [15:0] w_ppb = {15'h0000, persistent_protect_bit[sect]};
  wire [15:0] w_lock = {15'h0000, global_protect_lock};
  wire [15:0] w_dyb = {15'h0000, volatile_protect_bit[sect]};
  wire [15:0] w_trap = (addr[1:0] == ECC_TRAP_LO) ? ecc_trap_lo :
                       (addr[1:0] == ECC_TRAP_HI) ? ecc_trap_hi :
                       (addr[1:0] == ECC_COUNT) ? ecc_count : UNDEF_WORD;
  wire [15:0] w_ecc = (addr[7:6] == ECC_TRAP_AREA) ? w_trap :
                      {11'h000, ecc_status};
  wire [15:0] w_crc = crc_suspended ? array_data :
                      (addr[0] ? crc_value[31:16] : crc_value[15:0]);
  wire [15:0] w_map = (overlay == OV_CFG) ? w_cfg :
                      (overlay == OV_PWD) ? w_pwd :
                      (overlay == OV_PPB) ? w_ppb :
                      (overlay == OV_LOCK) ? w_lock :
                      (overlay == OV_DYB) ? w_dyb :
                      (overlay == OV_ECC) ? w_ecc :
                      (overlay == OV_CRC) ? w_crc : array_data;
  wire [15:0] next_rd = sr_pend ? {8'h00, sr_snap} : w_map;

  // one word back on the cycle after each sampled read
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= do_rd;
      if (do_rd)
        rd_data <= next_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_reset_ignored;
    busy & do_wr & (cmd == CMD_RESET) & ~op_done & ~op_fail |=> ctl_state == CS_BUSY;
  endproperty
  a_reset_ignored: assert property (p_reset_ignored) else $error("reset acted while busy");

  property p_reset_fast;
    c_reset |=> (overlay == OV_NORMAL) && (ctl_state == CS_STANDBY);
  endproperty
  a_reset_fast: assert property (p_reset_fast) else $error("reset not done next cycle");

  property p_err_status;
    err [*2] |-> status_word[SR_READY] && (status_word[2:1] == 2'b00);
  endproperty
  a_err_status: assert property (p_err_status) else $error("bad error status");

  property p_err_filter;
    err & do_wr & ~err_ok |=> $stable(ctl_state) && $stable(overlay);
  endproperty
  a_err_filter: assert property (p_err_filter) else $error("command taken in error");

  property p_clear_keeps;
    c_clear |=> (overlay == $past(overlay)) && (ctl_state != CS_ERROR);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clear lost overlay");

  property p_sr_read;
    do_rd & sr_pend |=> rd_valid && (rd_data == {8'h00, $past(sr_snap)}) && !sr_pend;
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("status read wrong");

  property p_lock_read;
    do_rd & ~sr_pend & (overlay == OV_LOCK) |=> rd_data == {15'h0000, $past(global_protect_lock)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

  property p_ppb_erase;
    c_erase & (overlay == OV_PPB) & global_protect_lock |=> persistent_protect_bit == 8'h00;
  endproperty
  a_ppb_erase: assert property (p_ppb_erase) else $error("erase left bits");

  property p_cfg_read;
    do_rd & ~sr_pend & (overlay == OV_CFG) & (addr == CFG_ADDR) |=> rd_data == $past(cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
endmodule

/* File: hw/ovc_pkg.sv */
package ovc_pkg;
  // word address and data widths of the command port
  localparam int AW = 8;
  localparam int DW = 16;
  // sector count and where the sector number sits in the word address
  localparam int NSECT = 8;
  localparam int SECT_LSB = 5;
  localparam int PWD_WORDS = 4;
  // status word bit positions
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PGM_ERR = 4;
  // overlay word locations
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [1:0] ECC_TRAP_AREA = 2'h3;
  localparam logic [1:0] ECC_TRAP_LO = 2'h0;
  localparam logic [1:0] ECC_TRAP_HI = 2'h1;
  localparam logic [1:0] ECC_COUNT = 2'h2;
  // values after reset
  localparam logic [15:0] CFG_RST = 16'hFFFF;
  localparam logic [15:0] PWD_RST = 16'hFFFF;
  localparam logic LOCK_RST = 1'b1;
  localparam logic [15:0] UNDEF_WORD = 16'h0000;

  // command codes as decoded by the bus front end
  typedef enum logic [4:0] {
    CMD_NOP = 5'b00000, CMD_RESET = 5'b00001, CMD_EXIT = 5'b00010,
    CMD_LEGACY_EXIT = 5'b00011, CMD_ENTER_CFG = 5'b00100,
    CMD_ENTER_PWD = 5'b00101, CMD_ENTER_PPB = 5'b00110,
    CMD_ENTER_LOCK = 5'b00111, CMD_ENTER_DYB = 5'b01000,
    CMD_ENTER_ECC = 5'b01001, CMD_ENTER_CRC = 5'b01010,
    CMD_ENTER_ID = 5'b01011, CMD_WORD_PGM = 5'b01100,
    CMD_ERASE = 5'b01101, CMD_BLANK_CHECK = 5'b01110,
    CMD_PWD_UNLOCK = 5'b01111, CMD_SR_READ = 5'b10000,
    CMD_SR_CLEAR = 5'b10001, CMD_CRC_START = 5'b10010,
    CMD_CRC_END = 5'b10011, CMD_CRC_SUSPEND = 5'b10100,
    CMD_CRC_RESUME = 5'b10101
  } ovc_cmd_e;

  // address space overlay in force
  typedef enum logic [3:0] {
    OV_NORMAL = 4'b0000, OV_CFG = 4'b0001, OV_PWD = 4'b0010,
    OV_PPB = 4'b0011, OV_LOCK = 4'b0100, OV_DYB = 4'b0101,
    OV_ECC = 4'b0110, OV_CRC = 4'b0111, OV_IDQ = 4'b1000
  } ovc_ov_e;

  // algorithm controller state
  typedef enum logic [1:0] {
    CS_STANDBY = 2'b00, CS_BUSY = 2'b01, CS_ERROR = 2'b10, CS_ESUSP = 2'b11
  } ovc_ctl_e;

  // embedded operation handed to the engine
  typedef enum logic [1:0] {
    OP_PGM = 2'b00, OP_ERASE = 2'b01, OP_BLANK = 2'b10
  } ovc_op_e;

  // one link transfer: a command write or a word read
  typedef struct packed {
    logic wr;
    logic rd;
    ovc_cmd_e cmd;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } ovc_req_s;
endpackage

/* File: test/ovc_host.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// host side of the link: one transfer per link clock period of 8 ref_clk
module ovc_host (
  input wire logic ref_clk,
  output logic link_ck,
  output ovc_pkg::ovc_req_s link_req
);
  import ovc_pkg::*;
  // link clock stands low between frames
  initial begin
    link_ck = 1'b0;
    link_req = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // request set up half a period before the rise and held half a period after;
  // the block needs at least 1 ref_clk of hold, we give 4
  task automatic xfer(input logic w, input ovc_cmd_e c, input logic [7:0] a,
                      input logic [15:0] d);
    @(negedge ref_clk);
    link_req <= '{wr: w, rd: !w, cmd: c, addr: a, data: d};
    repeat (4) @(negedge ref_clk);
    link_ck <= 1'b1;
    repeat (4) @(negedge ref_clk);
    link_ck <= 1'b0;
    // released lines show the inverse so a stale word never looks fresh
    link_req <= '{wr: 1'b0, rd: 1'b0, cmd: ovc_cmd_e'(~c), addr: ~a, data: ~d};
  endtask
endmodule

/* File: test/overlay_mode_and_error_control_bench.sv */
`timescale 1ns/1ns
module overlay_mode_and_error_control_bench;
  import ovc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic link_ck;
  ovc_req_s link_req;
  logic [15:0] array_data = 16'h3c3c;
  logic op_done = 1'b0;
  logic op_fail = 1'b0;
  logic op_timeout = 1'b0;
  logic erase_susp = 1'b0;
  logic [4:0] ecc_status = 5'h00;
  logic [15:0] ecc_trap_lo = 16'h1a2b;
  logic [15:0] ecc_trap_hi = 16'h3c4d;
  logic [15:0] ecc_count = 16'h0007;
  logic [31:0] crc_value = 32'ha5a5_5a5a;
  logic [15:0] rd_data, op_data, rd_word;
  logic [7:0] status_word, op_addr, crc_start_addr, crc_end_addr;
  logic [7:0] persistent_protect_bit, volatile_protect_bit;
  logic rd_valid, op_start, crc_run, crc_suspended, global_protect_lock;
  logic polling_timeout_flag;
  ovc_ov_e overlay;
  ovc_ctl_e ctl_state;
  ovc_op_e op_kind;
  int mismatches = 0;
  int cmp_count = 0;
  int rd_cnt = 0;
  int st_cnt = 0;
  // command lists for the failing operation loop
  ovc_cmd_e cmds[3] = '{CMD_WORD_PGM, CMD_ERASE, CMD_BLANK_CHECK};
  ovc_op_e kinds[3] = '{OP_PGM, OP_ERASE, OP_BLANK};
  logic [7:0] errs[3] = '{8'h90, 8'ha0, 8'ha0};

  always #10 ref_clk = ~ref_clk;

  ovc_host host (.ref_clk(ref_clk), .link_ck(link_ck), .link_req(link_req));
  ovc_ctl dut (.ref_clk(ref_clk), .reset(reset), .link_ck(link_ck), .link_req(link_req),
    .array_data(array_data), .op_done(op_done), .op_fail(op_fail), .op_timeout(op_timeout),
    .erase_susp(erase_susp), .ecc_status(ecc_status), .ecc_trap_lo(ecc_trap_lo),
    .ecc_trap_hi(ecc_trap_hi), .ecc_count(ecc_count), .crc_value(crc_value),
    .rd_data(rd_data), .rd_valid(rd_valid), .status_word(status_word), .overlay(overlay),
    .ctl_state(ctl_state), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .op_data(op_data), .crc_start_addr(crc_start_addr), .crc_end_addr(crc_end_addr),
    .crc_run(crc_run), .crc_suspended(crc_suspended),
    .global_protect_lock(global_protect_lock),
    .persistent_protect_bit(persistent_protect_bit),
    .volatile_protect_bit(volatile_protect_bit),
    .polling_timeout_flag(polling_timeout_flag));

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle pulses are caught here so a task never has to hit the exact edge
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      rd_word <= rd_data;
      rd_cnt <= rd_cnt + 1;
    end
    if (op_start === 1'b1) st_cnt <= st_cnt + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // command write, then two cycles for the state to land
  task automatic wr(input ovc_cmd_e c, input logic [7:0] a, input logic [15:0] d);
    host.xfer(1'b1, c, a, d);
    repeat (2) @(negedge ref_clk);
  endtask

  // word read; a missing answer shows up as an out-of-range value
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    int n0;
    n0 = rd_cnt;
    host.xfer(1'b0, CMD_NOP, a, 16'h0000);
    repeat (2) @(negedge ref_clk);
    chk(what, {16'h0000, exp}, (rd_cnt == n0 + 1) ? {16'h0000, rd_word} : 32'h0001_0000);
  endtask

  // engine answer, only if the block really handed an operation over
  task automatic fin(input logic fail);
    if (ctl_state === CS_BUSY) begin
      op_done <= !fail;
      op_fail <= fail;
      @(negedge ref_clk);
      op_done <= 1'b0;
      op_fail <= 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard: the run needs only about a thousand cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("status", 8'h80, status_word);
    $display("test reset done");
    // config overlay; a sector address in the entry must not matter
    wr(CMD_ENTER_CFG, 8'h60, 16'h0000);
    chk("ov cfg", OV_CFG, overlay);
    rd(CFG_ADDR, CFG_RST, "cfg word");
    wr(CMD_WORD_PGM, CFG_ADDR, 16'h1234);
    fin(1'b0);
    rd(CFG_ADDR, 16'h1234, "cfg pgm");
    rd(8'h05, UNDEF_WORD, "cfg undef");
    chk("ov kept", OV_CFG, overlay);
    wr(CMD_LEGACY_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    $display("test cfg done");
    // persistent bits: sector 2 set, erase clears all
    wr(CMD_ENTER_PPB, 8'h00, 16'h0000);
    wr(CMD_WORD_PGM, 8'h40, 16'h0001);
    fin(1'b0);
    rd(8'h5f, 16'h0001, "ppb set");
    rd(8'h20, 16'h0000, "ppb other");
    wr(CMD_ERASE, 8'h00, 16'h0000);
    fin(1'b0);
    rd(8'h40, 16'h0000, "ppb erased");
    chk("ppb bits", 8'h00, persistent_protect_bit);
    wr(CMD_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    // volatile bits: set then clear in sector 7
    wr(CMD_ENTER_DYB, 8'h00, 16'h0000);
    wr(CMD_WORD_PGM, 8'he0, 16'h0001);
    fin(1'b0);
    rd(8'hff, 16'h0001, "dyb set");
    wr(CMD_WORD_PGM, 8'he3, 16'h0000);
    fin(1'b0);
    rd(8'he0, 16'h0000, "dyb clear");
    wr(CMD_LEGACY_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    $display("test ppb dyb done");
    // global lock cleared, then set again by the password
    wr(CMD_ENTER_LOCK, 8'h00, 16'h0000);
    wr(CMD_WORD_PGM, 8'h77, 16'h0000);
    fin(1'b0);
    rd(8'hab, 16'h0000, "lock word");
    wr(CMD_EXIT, 8'h00, 16'h0000);
    wr(CMD_ENTER_PWD, 8'h80, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(CMD_WORD_PGM, 8'(i), 16'h2460 + 16'(i));
      fin(1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'(i), 16'h2460 + 16'(i), "pwd word");
    end
    rd(8'h04, UNDEF_WORD, "pwd undef");
    for (int i = 0; i < 4; i++) begin
      wr(CMD_PWD_UNLOCK, 8'(i), 16'h2460 + 16'(i));
    end
    fin(1'b0);
    chk("lock", 1'b1, global_protect_lock);
    // wrong last word: error held with ready and bit 4
    for (int i = 0; i < 4; i++) begin
      wr(CMD_PWD_UNLOCK, 8'(i), (i == 3) ? 16'h0bad : 16'h2460 + 16'(i));
    end
    fin(1'b1);
    chk("ctl err", CS_ERROR, ctl_state);
    chk("status", 8'h90, status_word);
    wr(CMD_EXIT, 8'h00, 16'h0000);
    chk("ov held", OV_PWD, overlay);
    chk("ctl held", CS_ERROR, ctl_state);
    wr(CMD_SR_READ, 8'h00, 16'h0000);
    rd(8'h02, 16'h0090, "sr read");
    chk("ov back", OV_PWD, overlay);
    wr(CMD_SR_CLEAR, 8'h00, 16'h0000);
    chk("ctl clr", CS_STANDBY, ctl_state);
    chk("status", 8'h80, status_word);
    chk("ov kept", OV_PWD, overlay);
    wr(CMD_LEGACY_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    $display("test lock pwd done");
    // correction overlay: status word and trap window
    ecc_status <= 5'h15;
    wr(CMD_ENTER_ECC, 8'h00, 16'h0000);
    rd(8'h10, 16'h0015, "ecc stat");
    rd(8'h1f, 16'h0015, "ecc stat");
    rd(8'hc0, 16'h1a2b, "trap lo");
    rd(8'hc1, 16'h3c4d, "trap hi");
    rd(8'hc2, 16'h0007, "ecc cnt");
    wr(CMD_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    $display("test ecc done");
    // check-value overlay and its own commands
    wr(CMD_ENTER_CRC, 8'h00, 16'h0000);
    wr(CMD_CRC_START, 8'h10, 16'h0000);
    chk("crc start", 8'h10, crc_start_addr);
    wr(CMD_CRC_END, 8'h2f, 16'h0000);
    chk("crc end", 8'h2f, crc_end_addr);
    chk("crc run", 1'b1, crc_run);
    rd(8'h00, 16'h5a5a, "crc lo");
    rd(8'h01, 16'ha5a5, "crc hi");
    wr(CMD_CRC_SUSPEND, 8'h00, 16'h0000);
    chk("crc susp", 1'b1, crc_suspended);
    array_data <= 16'h0ff0;
    rd(8'h44, 16'h0ff0, "crc array");
    wr(CMD_CRC_RESUME, 8'h00, 16'h0000);
    chk("crc susp", 1'b0, crc_suspended);
    wr(CMD_EXIT, 8'h00, 16'h0000);
    chk("ov exit", OV_NORMAL, overlay);
    chk("crc stop", 1'b0, crc_run);
    $display("test crc done");
    // failing operations: busy ignores reset, error holds, then cleared
    for (int i = 0; i < 3; i++) begin
      wr(cmds[i], 8'h33, 16'h5a5a);
      chk("op kind", kinds[i], op_kind);
      chk("op addr", 8'h33, op_addr);
      chk("op data", 16'h5a5a, op_data);
      chk("ctl busy", CS_BUSY, ctl_state);
      chk("ready", 1'b0, status_word[7]);
      wr(CMD_RESET, 8'h00, 16'h0000);
      chk("ctl busy", CS_BUSY, ctl_state);
      fin(1'b1);
      chk("status", errs[i], status_word);
      wr(CMD_ENTER_CFG, 8'h00, 16'h0000);
      chk("ov held", OV_NORMAL, overlay);
      wr((i == 1) ? CMD_SR_CLEAR : CMD_RESET, 8'h00, 16'h0000);
      chk("ctl clr", CS_STANDBY, ctl_state);
    end
    chk("op starts", 3, st_cnt);
    erase_susp <= 1'b1;
    wr(CMD_ERASE, 8'h40, 16'h0000);
    fin(1'b1);
    chk("status", 8'he0, status_word);
    wr(CMD_SR_CLEAR, 8'h00, 16'h0000);
    chk("ctl susp", CS_ESUSP, ctl_state);
    erase_susp <= 1'b0;
    wr(CMD_RESET, 8'h00, 16'h0000);
    chk("ctl std", CS_STANDBY, ctl_state);
    $display("test errors done");
    // timeout flag and id mode both cleared by reset; settings survive
    op_timeout <= 1'b1;
    @(negedge ref_clk);
    op_timeout <= 1'b0;
    wr(CMD_ENTER_ID, 8'h00, 16'h0000);
    chk("ov id in", OV_IDQ, overlay);
    chk("flag", 1'b1, polling_timeout_flag);
    wr(CMD_RESET, 8'h00, 16'h0000);
    chk("flag", 1'b0, polling_timeout_flag);
    chk("ov id", OV_NORMAL, overlay);
    wr(CMD_ENTER_CFG, 8'h00, 16'h0000);
    wr(CMD_RESET, 8'h00, 16'h0000);
    chk("ov cfg", OV_NORMAL, overlay);
    wr(CMD_ENTER_CFG, 8'h00, 16'h0000);
    rd(CFG_ADDR, 16'h1234, "cfg kept");
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule
